// ### hdl/jtc_consts.svh
`ifndef JTC_CONSTS_SVH
`define JTC_CONSTS_SVH
`define JTC_ADDR_W      24
`define JTC_WORD_W      16
`define JTC_WORD_STEP   24'h000002
`define JTC_RESUME_STEP 24'h000004
`define JTC_SEG_W       8
`endif

// ### hdl/jtc_pkg.sv
package jtc_pkg;
  typedef enum logic [2:0] {
    JK_NONE     = 3'h0,
    JK_RELATIVE = 3'h1,
    JK_ABSOLUTE = 3'h2,
    JK_BIT_TEST = 3'h3,
    JK_SEGMENT  = 3'h4,
    JK_SEG_CALL = 3'h5
  } jump_kind_t;

  typedef struct packed {
    logic [23:0] jump_addr;
    logic [23:0] target_addr;
    logic [15:0] word0;
    logic [15:0] word1;
  } cache_entry_t;

  typedef enum logic [1:0] {
    FS_IDLE   = 2'b00,
    FS_WORD0  = 2'b01,
    FS_WORD1  = 2'b11
  } fill_state_t;
endpackage

// ### hdl/jtc_entry.sv
`timescale 1ns/1ps
`include "jtc_consts.svh"
// Single entry storage for the jump target cache
module jtc_entry (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  invalidate_i,
  input  wire logic                  open_i,
  input  wire logic [23:0]           jump_addr_i,
  input  wire logic [23:0]           target_addr_i,
  input  wire logic                  wr0_i,
  input  wire logic                  wr1_i,
  input  wire logic [15:0]           word_i,
  output jtc_pkg::cache_entry_t      entry_o,
  output logic                       valid_o
);
  jtc_pkg::cache_entry_t entry_ff;
  logic                  valid_ff;

  // Valid only after both words landed; a new open drops the old entry [RL7]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_ff <= 1'b0;
    end else if (invalidate_i || open_i) begin
      valid_ff <= 1'b0;
    end else if (wr1_i) begin
      valid_ff <= 1'b1;
    end
  end

  // Entry contents, replaced by each new cacheable jump [RL7]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      entry_ff <= '0;
    end else begin
      if (open_i) begin
        entry_ff.jump_addr   <= jump_addr_i;
        entry_ff.target_addr <= target_addr_i;
      end
      if (wr0_i) begin
        entry_ff.word0 <= word_i; // [RL2]
      end
      if (wr1_i) begin
        entry_ff.word1 <= word_i; // [RL2]
      end
    end
  end

  assign entry_o = entry_ff;
  assign valid_o = valid_ff;
endmodule

// ### hdl/jump_target_cache.sv
// Contract
// RL1: Load the cache only on taken relative, absolute or bit-test jumps.
// RL2: Store the target word at A and the next word at A+2.
// RL3: After delivering both cached words on a hit, fetch continues at A+4.
// RL4: Hit only for same jump, with no cacheable, segment jump/call or interrupt between.
// RL5: An event transfer right after a taken relative jump leaves the entry intact.
// RL6: The relative jump counts as one word when computing fetch addresses.
// RL7: One entry only; each new cacheable jump replaces it; invalid after reset.
`timescale 1ns/1ps
`include "jtc_consts.svh"
module jump_target_cache (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  // Decode side: a jump resolved this cycle
  input  wire logic                  jump_valid_i,
  input  wire jtc_pkg::jump_kind_t   jump_kind_i,
  input  wire logic                  jump_taken_i,
  input  wire logic [23:0]           jump_addr_i,
  input  wire logic [23:0]           jump_target_i,
  input  wire logic                  interrupt_taken_i,
  input  wire logic                  event_xfer_i,
  // Program memory fetch return for the target words
  input  wire logic                  fetch_done_i,
  input  wire logic [15:0]           fetch_data_i,
  // Pipeline side
  input  wire logic                  pipe_ready_i,
  output logic                       hit_o,
  output logic                       word_valid_o,
  output logic [15:0]                word_o,
  output logic                       resume_valid_o,
  output logic [23:0]                resume_addr_o
);
  // Entry view and fill control
  jtc_pkg::cache_entry_t entry;
  jtc_pkg::fill_state_t  fill_ff;
  logic                  valid;
  logic                  cacheable;
  logic                  lookup;
  logic                  hit;
  logic                  open_load;
  logic                  wr0;
  logic                  wr1;
  logic                  invalidate;
  logic                  kind_fills;
  logic                  kind_flushes;
  jtc_pkg::fill_state_t  nxt_fill;
  logic [1:0]            deliver_ff;
  logic                  hit_ff;
  logic [15:0]           word_ff;
  logic                  word_valid_ff;
  logic                  resume_valid_ff;
  logic [23:0]           resume_addr_ff;
  logic [23:0]           resume_base_ff;

  // Kind decode: which jumps may fill, which ones leave the code segment
  always_comb begin
    kind_fills   = 1'b0;
    kind_flushes = 1'b0;
    case (jump_kind_i)
      jtc_pkg::JK_RELATIVE: begin
        kind_fills = 1'b1; // One-word jump, still cacheable [RL1] [RL6]
      end
      jtc_pkg::JK_ABSOLUTE: begin
        kind_fills = 1'b1; // [RL1]
      end
      jtc_pkg::JK_BIT_TEST: begin
        kind_fills = 1'b1; // [RL1]
      end
      jtc_pkg::JK_SEGMENT: begin
        kind_flushes = 1'b1; // [RL4]
      end
      jtc_pkg::JK_SEG_CALL: begin
        kind_flushes = 1'b1; // [RL4]
      end
      default: begin
        kind_fills   = 1'b0;
        kind_flushes = 1'b0;
      end
    endcase
  end

  // Cacheable kinds, and only when actually taken [RL1]
  assign cacheable = jump_valid_i && jump_taken_i && kind_fills;
  // Hit needs the same jump; any other cacheable jump refills instead [RL4]
  assign lookup    = cacheable && valid && (entry.jump_addr == jump_addr_i);
  assign hit       = lookup && (entry.target_addr == jump_target_i);
  assign open_load = cacheable && !hit; // [RL1] [RL7]

  // Segment changes and interrupts kill the entry; event transfers do not [RL4] [RL5]
  assign invalidate = interrupt_taken_i || (jump_valid_i && jump_taken_i && kind_flushes);

  // Fill tracks the two target fetches; event transfer data is never captured [RL5]
  always_comb begin
    nxt_fill = fill_ff;
    if (invalidate) begin
      nxt_fill = jtc_pkg::FS_IDLE;
    end else if (open_load) begin
      nxt_fill = jtc_pkg::FS_WORD0; // A new jump restarts an unfinished fill [RL7]
    end else begin
      case (fill_ff)
        jtc_pkg::FS_IDLE: begin
          nxt_fill = jtc_pkg::FS_IDLE;
        end
        jtc_pkg::FS_WORD0: begin
          if (fetch_done_i && !event_xfer_i) begin
            nxt_fill = jtc_pkg::FS_WORD1;
          end
        end
        jtc_pkg::FS_WORD1: begin
          if (fetch_done_i && !event_xfer_i) begin
            nxt_fill = jtc_pkg::FS_IDLE;
          end
        end
        default: begin
          nxt_fill = jtc_pkg::FS_IDLE;
        end
      endcase
    end
  end

  // Fill state register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fill_ff <= jtc_pkg::FS_IDLE;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  // Entry write strobes; an event transfer slot never lands in the entry
  assign wr0 = !invalidate && !open_load && fill_ff == jtc_pkg::FS_WORD0 &&
               fetch_done_i && !event_xfer_i; // [RL2] [RL5]
  assign wr1 = !invalidate && !open_load && fill_ff == jtc_pkg::FS_WORD1 &&
               fetch_done_i && !event_xfer_i; // [RL2] [RL5]

  // Single entry; a newer cacheable jump simply overwrites it [RL7]
  jtc_entry jtc_entry_inst (
    .mclk_i        (mclk_i),
    .rst_b_i       (rst_b_i),
    .invalidate_i  (invalidate),
    .open_i        (open_load),
    .jump_addr_i   (jump_addr_i),
    .target_addr_i (jump_target_i),
    .wr0_i         (wr0),
    .wr1_i         (wr1),
    .word_i        (fetch_data_i),
    .entry_o       (entry),
    .valid_o       (valid)
  );

  // Delivery counter: words still owed to the pipeline after a hit [RL2]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      deliver_ff <= 2'h0;
    end else if (hit) begin
      deliver_ff <= 2'h2;
    end else if (deliver_ff != 2'h0 && pipe_ready_i) begin
      deliver_ff <= deliver_ff - 2'h1;
    end
  end

  // Resume base from the stored target, never from live fetch state, so
  // an event transfer during the fill cannot shift it [RL5] [RL6]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resume_base_ff <= 24'h000000;
    end else if (hit) begin
      resume_base_ff <= entry.target_addr;
    end
  end

  // Hit flag, one cycle after the jump edge [RL4]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= hit;
    end
  end

  // Word presented to the pipeline: word0 first, then word1 [RL2]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_ff <= 16'h0000;
    end else if (hit) begin
      word_ff <= entry.word0;
    end else if (deliver_ff == 2'h2 && pipe_ready_i) begin
      word_ff <= entry.word1;
    end
  end

  // Word stands until taken; drops after word1 is accepted [RL2] [RL3]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_valid_ff <= 1'b0;
    end else if (hit) begin
      word_valid_ff <= 1'b1;
    end else if (deliver_ff == 2'h2 && pipe_ready_i) begin
      word_valid_ff <= 1'b1;
    end else if (pipe_ready_i) begin
      word_valid_ff <= 1'b0;
    end
  end

  // One-cycle resume pulse once word1 is taken [RL3]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resume_valid_ff <= 1'b0;
    end else begin
      resume_valid_ff <= (deliver_ff == 2'h1) && pipe_ready_i;
    end
  end

  // Fetch resumes at A+4; the word at A+2 is never fetched again [RL3] [RL6]
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resume_addr_ff <= 24'h000000;
    end else if (deliver_ff == 2'h1 && pipe_ready_i) begin
      resume_addr_ff <= resume_base_ff + `JTC_RESUME_STEP; // [RL3]
    end
  end

  // Outputs come straight from flip-flops
  assign hit_o          = hit_ff;
  assign word_valid_o   = word_valid_ff;
  assign word_o         = word_ff;
  assign resume_valid_o = resume_valid_ff;
  assign resume_addr_o  = resume_addr_ff;
endmodule

// ### test/jtc_monitor.sv
`timescale 1ns/1ps
module jtc_monitor (
  input wire logic                mclk_i,
  input wire logic                rst_b_i,
  input wire logic                jump_valid_i,
  input wire jtc_pkg::jump_kind_t jump_kind_i,
  input wire logic                jump_taken_i,
  input wire logic [23:0]         jump_target_i,
  input wire logic                interrupt_taken_i,
  input wire logic                pipe_ready_i,
  input wire logic                hit_o,
  input wire logic                word_valid_o,
  input wire logic [15:0]         word_o,
  input wire logic                resume_valid_o,
  input wire logic [23:0]         resume_addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [23:0] tgt_ff;
  // Last target seen; bench never jumps while words are pending
  always_ff @(posedge mclk_i) if (jump_valid_i) tgt_ff <= jump_target_i;
  sequence s_take; word_valid_o && pipe_ready_i; endsequence
  sequence s_flush;
    interrupt_taken_i || jump_valid_i && jump_taken_i && jump_kind_i inside {[3'h4:3'h5]};
  endsequence
  a_hit_cause: assert property (hit_o |-> $past(jump_valid_i && jump_taken_i) && word_valid_o)
    else $error("hit without taken jump");
  a_hit_kind: assert property (hit_o |-> $past(jump_kind_i) inside {[3'h1:3'h3]})
    else $error("hit on uncacheable kind");
  a_flush_miss: assert property (s_flush |=> !hit_o ##1 !hit_o)
    else $error("hit after flush");
  a_word_hold: assert property (word_valid_o && !pipe_ready_i |=> word_valid_o && $stable(word_o))
    else $error("word dropped");
  a_second_word: assert property (hit_o ##0 s_take |=> word_valid_o)
    else $error("second word missing");
  a_resume_addr: assert property (resume_valid_o |-> resume_addr_o == tgt_ff + 24'h4)
    else $error("bad resume address");
  a_resume_cause: assert property (resume_valid_o |-> $past(word_valid_o) && !word_valid_o)
    else $error("resume out of turn");
  a_resume_once: assert property (resume_valid_o |=> !resume_valid_o)
    else $error("resume too long");
endmodule
bind jump_target_cache jtc_monitor jtc_monitor_inst (
  .mclk_i            (mclk_i),
  .rst_b_i           (rst_b_i),
  .jump_valid_i      (jump_valid_i),
  .jump_kind_i       (jump_kind_i),
  .jump_taken_i      (jump_taken_i),
  .jump_target_i     (jump_target_i),
  .interrupt_taken_i (interrupt_taken_i),
  .pipe_ready_i      (pipe_ready_i),
  .hit_o             (hit_o),
  .word_valid_o      (word_valid_o),
  .word_o            (word_o),
  .resume_valid_o    (resume_valid_o),
  .resume_addr_o     (resume_addr_o)
);

// ### test/jtc_mem_model.sv
`timescale 1ns/1ps
// Program memory: optional event slot, then words at A and A+2
module jtc_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        go_i,
  input  wire logic        pec_i,
  input  wire logic [23:0] addr_i,
  output logic             fetch_done_o,
  output logic             event_xfer_o,
  output logic [15:0]      fetch_data_o
);
  logic [1:0]  step_ff;
  logic        pec_ff;
  logic [23:0] addr_ff;
  logic [15:0] junk_ff;
  // Junk keeps the idle bus moving so stale data is never reused
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_ff <= 2'h0;
      junk_ff <= 16'h0000;
    end else begin
      junk_ff <= junk_ff + 16'h9e37;
      if (go_i) begin
        step_ff <= 2'h1;
        pec_ff <= pec_i;
        addr_ff <= addr_i;
      end else if (step_ff != 2'h0) step_ff <= step_ff + 2'h1;
    end
  end
  assign event_xfer_o = step_ff == 2'h1 && pec_ff;
  assign fetch_done_o = step_ff[1] || event_xfer_o;
  assign fetch_data_o = step_ff == 2'h2 ? addr_ff[15:0] ^ 16'hc3a5 :
                        step_ff == 2'h3 ? (addr_ff[15:0] + 16'h0002) ^ 16'hc3a5 : junk_ff;
endmodule

// ### test/test_jump_target_cache.sv
`timescale 1ns/1ps
module test_jump_target_cache;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, jump_valid_i = 1'b0, jump_taken_i = 1'b0;
  logic interrupt_taken_i = 1'b0, pipe_ready_i = 1'b0, go = 1'b0, pec = 1'b0;
  logic fetch_done_i, event_xfer_i, hit_o, word_valid_o, resume_valid_o;
  logic [23:0] jump_addr_i = 24'h0, jump_target_i = 24'h0, maddr = 24'h0, ja, tg;
  logic [23:0] resume_addr_o;
  logic [15:0] fetch_data_i, word_o;
  jtc_pkg::jump_kind_t jump_kind_i = jtc_pkg::JK_NONE;
  logic [23:0] exp_q[$];
  int miscompares = 0, n_checks = 0, n_hit_exp = 0, n_hit_seen = 0, cyc = 0;
  jump_target_cache jump_target_cache_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .jump_valid_i(jump_valid_i), .jump_kind_i(jump_kind_i), .jump_taken_i(jump_taken_i),
    .jump_addr_i(jump_addr_i), .jump_target_i(jump_target_i),
    .interrupt_taken_i(interrupt_taken_i), .event_xfer_i(event_xfer_i),
    .fetch_done_i(fetch_done_i), .fetch_data_i(fetch_data_i), .pipe_ready_i(pipe_ready_i),
    .hit_o(hit_o), .word_valid_o(word_valid_o), .word_o(word_o),
    .resume_valid_o(resume_valid_o), .resume_addr_o(resume_addr_o));
  jtc_mem_model jtc_mem_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .go_i(go), .pec_i(pec),
    .addr_i(maddr), .fetch_done_o(fetch_done_i), .event_xfer_o(event_xfer_i),
    .fetch_data_o(fetch_data_i));
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) pipe_ready_i <= 1'($urandom);
  function automatic logic [23:0] wd(input logic [23:0] a);
    return {8'h00, a[15:0] ^ 16'hc3a5};
  endfunction
  task automatic report(input string name, input logic [23:0] e, input logic [23:0] v);
    n_checks++;
    if (v !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", name, e, v);
    end
  endtask
  // Oldest note against each accepted word or resume
  always @(posedge mclk_i) begin
    if (word_valid_o === 1'b1 && pipe_ready_i === 1'b1)
      report("word_o", exp_q.size() ? exp_q.pop_front() : 24'hxxxxxx, {8'h00, word_o});
    if (resume_valid_o === 1'b1)
      report("resume_addr_o", exp_q.size() ? exp_q.pop_front() : 24'hxxxxxx, resume_addr_o);
    if (hit_o === 1'b1) n_hit_seen++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // Kind none stands for an interrupt pulse
  task automatic jmp(input jtc_pkg::jump_kind_t k, input logic t, input logic [23:0] j,
                     input logic [23:0] a, input logic p, input logic h);
    @(posedge mclk_i);
    jump_valid_i <= k != jtc_pkg::JK_NONE;
    interrupt_taken_i <= k == jtc_pkg::JK_NONE;
    jump_kind_i <= k;
    jump_taken_i <= t;
    jump_addr_i <= j;
    jump_target_i <= a;
    if (h) begin
      n_hit_exp++;
      exp_q.push_back(wd(a));
      exp_q.push_back(wd(a + 24'h2));
      exp_q.push_back(a + 24'h4);
    end else if (t && k inside {[3'h1:3'h3]}) begin
      go <= 1'b1;
      maddr <= a;
      pec <= p;
    end
    @(posedge mclk_i);
    jump_valid_i <= 1'b0;
    interrupt_taken_i <= 1'b0;
    go <= 1'b0;
    for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge mclk_i);
    repeat (6) @(posedge mclk_i);
    report("hit count", 24'(n_hit_exp) + 24'(exp_q.size()), 24'(n_hit_seen));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h5ae902d0));
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    ja = 24'h000100;
    tg = 24'($urandom) & 24'hfffffe;
    jmp(jtc_pkg::JK_RELATIVE, 1, ja, tg, 1, 0);
    jmp(jtc_pkg::JK_RELATIVE, 1, ja, tg, 0, 1);
    jmp(jtc_pkg::JK_RELATIVE, 0, ja, tg, 0, 0);
    jmp(jtc_pkg::JK_RELATIVE, 1, ja, tg, 0, 1);
    $display("test fill and hit done");
    for (int k = 1; k < 4; k++) begin
      jmp(jtc_pkg::jump_kind_t'(k), 1, ja + 24'(k * 16), tg, 0, 0);
      jmp(jtc_pkg::jump_kind_t'(k), 1, ja + 24'(k * 16), tg, 0, 1);
    end
    $display("test kinds done");
    for (int k = 4; k < 7; k++) begin
      jmp(jtc_pkg::jump_kind_t'(k % 6), 1, ja + 24'h40, tg + 24'h8, 0, 0);
      jmp(jtc_pkg::JK_BIT_TEST, 1, ja + 24'h30, tg, 0, 0);
      jmp(jtc_pkg::JK_BIT_TEST, 1, ja + 24'h30, tg, 0, 1);
    end
    $display("test flush done");
    jmp(jtc_pkg::JK_ABSOLUTE, 1, ja, tg + 24'h20, 1, 0);
    jmp(jtc_pkg::JK_BIT_TEST, 1, ja + 24'h30, tg, 0, 0);
    jmp(jtc_pkg::JK_BIT_TEST, 1, ja + 24'h30, tg, 0, 1);
    $display("test replace done");
    complete_run();
  end
endmodule
